// ===== hw/pulse_pkg.sv
// Constants for the energy pulse spacing output block.
// Assumes a single 200 MHz core clock and an AXI4-Lite register bus.
package pulse_pkg;
	// ====================================================================
	// Register map (word indices, byte address is four times the index)
	localparam logic [13:0] IDX_WIDTH_LIMIT = 14'h210A;
	localparam logic [13:0] IDX_SPACING     = 14'h210B;
	localparam logic [13:0] IDX_POLARITY    = 14'h210C;
	localparam logic [13:0] IDX_STATUS      = 14'h2110;
	localparam int          ADDR_W          = 16;
	localparam logic [7:0]  RST_WIDTH_LIMIT = 8'hFF;
	localparam logic [7:0]  RST_SPACING     = 8'h00;
	localparam logic        RST_POLARITY    = 1'b0;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// ====================================================================
	// Timing
	localparam int          CORE_MHZ        = 200;
	localparam int          FILTER_KHZ      = 5000;
	localparam int          FILTER_DIV      = (CORE_MHZ * 1000) / FILTER_KHZ;
	localparam logic [7:0]  FILTER_DIV_LAST = 8'(FILTER_DIV - 1);
	localparam int          SPACING_MULT    = 4;
	localparam int          NUM_CH          = 4;
	localparam int          PEND_W          = 4;
	localparam int          WIDTH_CNT_W     = 17;
	localparam int          PERIOD_W        = 10;
	// ====================================================================
	// Channel numbering
	localparam int          CH_REAL         = 0;
	localparam int          CH_REACTIVE     = 1;
endpackage

// ===== hw/spacing_cfg_if.sv
// Interface carrying spacing configuration and timing strobes to each channel.
// Assumes one driver (the top module) and any number of channel readers.
interface spacing_cfg_if;
	logic       filter_tick;
	logic       period_strobe;
	logic [7:0] spacing;
	logic [7:0] width_limit;
	modport source (output filter_tick, output period_strobe, output spacing,
		output width_limit);
	modport sink   (input filter_tick, input period_strobe, input spacing,
		input width_limit);
endinterface

// ===== hw/pulse_channel.sv
// One pulse channel: queue of pending pulses and the width-limited output.
// Assumes issue pulses are synchronous to the clock and one cycle long.
module pulse_channel
	import pulse_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       issue,
	spacing_cfg_if.sink     cfg,
	output logic            active,
	output logic            pending_any
);
	logic [PEND_W-1:0]      pending;
	logic [PEND_W-1:0]      next_pending;
	logic [WIDTH_CNT_W-1:0] width_cnt;
	logic [WIDTH_CNT_W-1:0] next_width_cnt;
	logic                   next_active;
	logic                   release_now;
	logic                   full;

	// ====================================================================
	// Queue and pulse shaping
	always_comb begin
		full           = &pending;
		release_now    = cfg.period_strobe && (pending != '0) && (cfg.spacing != 8'h00);
		next_pending   = pending;
		next_active    = active;
		next_width_cnt = width_cnt;
		if (cfg.spacing == 8'h00) begin
			next_pending = '0;
			next_active  = issue;
		end else begin
			if (issue && !full && !release_now) begin
				next_pending = pending + 1'b1;
			end else if (release_now && !(issue && !full)) begin
				next_pending = pending - 1'b1;
			end
			if (release_now) begin
				next_active    = 1'b1;
				next_width_cnt = WIDTH_CNT_W'(({9'h000, cfg.width_limit} * 2 + 1)
					* {9'h000, cfg.spacing});
			end else if (active && cfg.filter_tick) begin
				next_width_cnt = width_cnt - 1'b1;
				if (width_cnt <= 17'h00001) begin
					next_active = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pending   <= '0;
			active    <= 1'b0;
			width_cnt <= '0;
		end else begin
			pending   <= next_pending;
			active    <= next_active;
			width_cnt <= next_width_cnt;
		end
	end

	assign pending_any = (pending != '0);
endmodule

// ===== hw/energy_pulse_spacing_output.sv
// Energy pulse spacing output: paces compute engine pulses onto output pins.
// Assumes CORE_CLK at 200 MHz, synchronous RST and an AXI4-Lite master.
//
// Decided for this implementation: the AXI4-Lite slave port.
module energy_pulse_spacing_output
	import pulse_pkg::*;
(
	input  wire logic                   CORE_CLK,
	input  wire logic                   RST,
	input  wire logic [NUM_CH-1:0]      CE_PULSE,
	output logic      [NUM_CH-1:0]      PULSE_OUT,
	input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic [1:0]                  S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic [31:0]                 S_AXI_RDATA,
	output logic [1:0]                  S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY
);
	spacing_cfg_if cfg ();

	logic [7:0]          width_limit;
	logic [7:0]          spacing;
	logic                polarity_invert;
	logic [7:0]          next_width_limit;
	logic [7:0]          next_spacing;
	logic                next_polarity_invert;
	logic [7:0]          div_cnt;
	logic [7:0]          next_div_cnt;
	logic                filter_tick;
	logic                next_filter_tick;
	logic [PERIOD_W-1:0] period_cnt;
	logic [PERIOD_W-1:0] next_period_cnt;
	logic [PERIOD_W-1:0] period_last;
	logic                period_strobe;
	logic                next_period_strobe;
	logic [NUM_CH-1:0]   active;
	logic [NUM_CH-1:0]   pending_any;
	logic [NUM_CH-1:0]   next_pulse_out;

	logic [ADDR_W-1:0]   aw_addr;
	logic                aw_held;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                w_held;
	logic [ADDR_W-1:0]   next_aw_addr;
	logic                next_aw_held;
	logic [31:0]         next_w_data;
	logic [3:0]          next_w_strb;
	logic                next_w_held;
	logic                next_awready;
	logic                next_wready;
	logic                next_bvalid;
	logic [1:0]          next_bresp;
	logic                next_arready;
	logic                next_rvalid;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;
	logic [13:0]         wr_idx;
	logic [13:0]         rd_idx;
	logic                do_write;

	// ====================================================================
	// Filter clock enable and spacing period strobe
	always_comb begin
		period_last        = PERIOD_W'({2'h0, spacing} * SPACING_MULT - 1);
		next_filter_tick   = (div_cnt == FILTER_DIV_LAST);
		next_div_cnt       = next_filter_tick ? 8'h00 : div_cnt + 8'h01;
		next_period_strobe = 1'b0;
		next_period_cnt    = period_cnt;
		if (spacing == 8'h00) begin
			next_period_cnt = '0;
		end else if (filter_tick) begin
			if (period_cnt >= period_last) begin
				next_period_cnt    = '0;
				next_period_strobe = 1'b1;
			end else begin
				next_period_cnt = period_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			div_cnt       <= 8'h00;
			filter_tick   <= 1'b0;
			period_cnt    <= '0;
			period_strobe <= 1'b0;
		end else begin
			div_cnt       <= next_div_cnt;
			filter_tick   <= next_filter_tick;
			period_cnt    <= next_period_cnt;
			period_strobe <= next_period_strobe;
		end
	end

	assign cfg.filter_tick   = filter_tick;
	assign cfg.period_strobe = period_strobe;
	assign cfg.spacing       = spacing;
	assign cfg.width_limit   = width_limit;

	// ====================================================================
	// Channels
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			pulse_channel u_ch (
				.clk         (CORE_CLK),
				.rst         (RST),
				.issue       (CE_PULSE[ch]),
				.cfg         (cfg),
				.active      (active[ch]),
				.pending_any (pending_any[ch])
			);
		end
	endgenerate

	// ====================================================================
	// Output polarity
	always_comb begin
		next_pulse_out = active;
		next_pulse_out[CH_REAL]     = active[CH_REAL] ^ ~polarity_invert;
		next_pulse_out[CH_REACTIVE] = active[CH_REACTIVE] ^ ~polarity_invert;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			PULSE_OUT <= {{(NUM_CH-2){1'b0}}, 2'h3};
		end else begin
			PULSE_OUT <= next_pulse_out;
		end
	end

	// ====================================================================
	// AXI4-Lite register slave
	always_comb begin
		next_aw_addr  = aw_addr;
		next_aw_held  = aw_held;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_w_held   = w_held;
		next_bvalid   = S_AXI_BVALID;
		next_bresp    = S_AXI_BRESP;
		next_width_limit     = width_limit;
		next_spacing         = spacing;
		next_polarity_invert = polarity_invert;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_addr = S_AXI_AWADDR;
			next_aw_held = 1'b1;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_data = S_AXI_WDATA;
			next_w_strb = S_AXI_WSTRB;
			next_w_held = 1'b1;
		end
		wr_idx   = aw_addr[ADDR_W-1:2];
		do_write = aw_held && w_held && !S_AXI_BVALID;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (wr_idx == IDX_WIDTH_LIMIT) begin
				if (w_strb[0]) next_width_limit = w_data[7:0];
			end else if (wr_idx == IDX_SPACING) begin
				if (w_strb[0]) next_spacing = w_data[7:0];
			end else if (wr_idx == IDX_POLARITY) begin
				if (w_strb[0]) next_polarity_invert = w_data[0];
			end else if (wr_idx != IDX_STATUS) begin
				next_bresp = RESP_SLVERR;
			end
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;

		rd_idx       = S_AXI_ARADDR[ADDR_W-1:2];
		next_rvalid  = S_AXI_RVALID;
		next_rdata   = S_AXI_RDATA;
		next_rresp   = S_AXI_RRESP;
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			case (rd_idx)
				IDX_WIDTH_LIMIT: next_rdata[7:0] = width_limit;
				IDX_SPACING:     next_rdata[7:0] = spacing;
				IDX_POLARITY:    next_rdata[0]   = polarity_invert;
				IDX_STATUS:      next_rdata[7:0] = {pending_any, active};
				default:         next_rresp      = RESP_SLVERR;
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			width_limit     <= RST_WIDTH_LIMIT;
			spacing         <= RST_SPACING;
			polarity_invert <= RST_POLARITY;
			aw_addr         <= '0;
			aw_held         <= 1'b0;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			w_held          <= 1'b0;
			S_AXI_AWREADY   <= 1'b0;
			S_AXI_WREADY    <= 1'b0;
			S_AXI_BVALID    <= 1'b0;
			S_AXI_BRESP     <= RESP_OKAY;
			S_AXI_ARREADY   <= 1'b0;
			S_AXI_RVALID    <= 1'b0;
			S_AXI_RDATA     <= 32'h0000_0000;
			S_AXI_RRESP     <= RESP_OKAY;
		end else begin
			width_limit     <= next_width_limit;
			spacing         <= next_spacing;
			polarity_invert <= next_polarity_invert;
			aw_addr         <= next_aw_addr;
			aw_held         <= next_aw_held;
			w_data          <= next_w_data;
			w_strb          <= next_w_strb;
			w_held          <= next_w_held;
			S_AXI_AWREADY   <= next_awready;
			S_AXI_WREADY    <= next_wready;
			S_AXI_BVALID    <= next_bvalid;
			S_AXI_BRESP     <= next_bresp;
			S_AXI_ARREADY   <= next_arready;
			S_AXI_RVALID    <= next_rvalid;
			S_AXI_RDATA     <= next_rdata;
			S_AXI_RRESP     <= next_rresp;
		end
	end
endmodule

// ===== test/pulse_engine_model.sv
// Compute engine model: issues bursts of one-cycle pulses.
// Assumes the bench raises start for one cycle and waits for busy to fall.
module pulse_engine_model (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [3:0] chans,
	input  wire logic [7:0] num,
	output logic      [3:0] ce_pulse,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====================================================================
	// Burst issue
	initial begin
		ce_pulse = 4'h0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (start) begin
				busy <= 1'b1;
				for (int i = 0; i < num; i++) begin
					ce_pulse <= chans;
					@(posedge clk);
					ce_pulse <= 4'h0;
					repeat (1 + $urandom_range(3)) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

// ===== test/energy_pulse_spacing_output_sva.sv
// Checker for the pulse spacing block, bound to its top module.
// Assumes write address and data are taken at the same edge.
module energy_pulse_spacing_output_sva
	import pulse_pkg::*;
(
	input wire logic              CORE_CLK,
	input wire logic              RST,
	input wire logic [NUM_CH-1:0] CE_PULSE,
	input wire logic [NUM_CH-1:0] PULSE_OUT,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic              S_AXI_AWVALID,
	input wire logic              S_AXI_AWREADY,
	input wire logic [31:0]       S_AXI_WDATA,
	input wire logic [3:0]        S_AXI_WSTRB,
	input wire logic              S_AXI_WVALID,
	input wire logic              S_AXI_WREADY,
	input wire logic              S_AXI_BVALID,
	input wire logic              S_AXI_BREADY,
	input wire logic              S_AXI_ARVALID,
	input wire logic              S_AXI_ARREADY,
	input wire logic [31:0]       S_AXI_RDATA,
	input wire logic              S_AXI_RVALID,
	input wire logic              S_AXI_RREADY
);
	logic        wr;
	logic [7:0]  spc;
	logic [7:0]  wl;
	logic        pol;
	logic [15:0] gap;
	int          hi;
	// ====================================================================
	// Shadow registers and counters
	assign wr = S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY & S_AXI_WSTRB[0];
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			spc <= 8'h00;
			wl <= 8'hFF;
			pol <= 1'b0;
		end else if (wr) begin
			if (S_AXI_AWADDR[15:2] == IDX_SPACING) spc <= S_AXI_WDATA[7:0];
			if (S_AXI_AWADDR[15:2] == IDX_WIDTH_LIMIT) wl <= S_AXI_WDATA[7:0];
			if (S_AXI_AWADDR[15:2] == IDX_POLARITY) pol <= S_AXI_WDATA[0];
		end
		if (RST || wr) gap <= 16'hFFFF;
		else if ($rose(PULSE_OUT[2])) gap <= 16'h0000;
		else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
		hi <= PULSE_OUT[2] ? hi + 1 : 0;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ====================================================================
	// Assertions
	reset_idle_a: assert property (disable iff (1'b0) RST |=> PULSE_OUT == 4'h3 && !S_AXI_RVALID)
		else $error("Outputs not idle after reset.");
	bypass_pulse_a: assert property (spc == 0 && CE_PULSE[2] |-> ##2 PULSE_OUT[2] ##1 !PULSE_OUT[2])
		else $error("Bypass pulse wrong.");
	main_polarity_a: assert property (spc == 0 && CE_PULSE[0] |-> ##2 PULSE_OUT[0] == pol)
		else $error("Main pulse polarity wrong.");
	aux_polarity_a: assert property (pol && spc == 0 && CE_PULSE[3] |-> ##2 PULSE_OUT[3])
		else $error("Aux pulse polarity wrong.");
	pulse_gap_a: assert property (spc != 0 && $rose(PULSE_OUT[2]) |-> gap >= spc * 160 - 1)
		else $error("Pulses too close.");
	width_limit_a: assert property (spc != 0 && PULSE_OUT[2] |-> hi <= (2 * wl + 1) * spc * 40 + 40)
		else $error("Pulse too wide.");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("Read answer late.");
	read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("Read data not held.");
	write_answer_a: assert property (wr |-> ##2 S_AXI_BVALID)
		else $error("Write answer late.");
	write_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("Write response dropped.");
endmodule
bind energy_pulse_spacing_output energy_pulse_spacing_output_sva energy_pulse_spacing_output_sva_i (
	.CORE_CLK      (CORE_CLK),
	.RST           (RST),
	.CE_PULSE      (CE_PULSE),
	.PULSE_OUT     (PULSE_OUT),
	.S_AXI_AWADDR  (S_AXI_AWADDR),
	.S_AXI_AWVALID (S_AXI_AWVALID),
	.S_AXI_AWREADY (S_AXI_AWREADY),
	.S_AXI_WDATA   (S_AXI_WDATA),
	.S_AXI_WSTRB   (S_AXI_WSTRB),
	.S_AXI_WVALID  (S_AXI_WVALID),
	.S_AXI_WREADY  (S_AXI_WREADY),
	.S_AXI_BVALID  (S_AXI_BVALID),
	.S_AXI_BREADY  (S_AXI_BREADY),
	.S_AXI_ARVALID (S_AXI_ARVALID),
	.S_AXI_ARREADY (S_AXI_ARREADY),
	.S_AXI_RDATA   (S_AXI_RDATA),
	.S_AXI_RVALID  (S_AXI_RVALID),
	.S_AXI_RREADY  (S_AXI_RREADY)
);

// ===== test/energy_pulse_spacing_output_tb_top.sv
// Testbench for the pulse spacing block with an engine model.
// Assumes the package constants and an idle-ready register bus.
module energy_pulse_spacing_output_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pulse_pkg::*;
	logic CORE_CLK = 0, RST = 1, start = 0, busy, pol_b = 0;
	logic [3:0] CE_PULSE, PULSE_OUT, chans = 0, act, act_q = 0, S_AXI_WSTRB = 0;
	logic [7:0] num = 0;
	logic [15:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
	logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, d;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
	logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	int n_mismatch = 0, n_compared = 0, cyc = 0, spc;
	int n_act[4], n_exp[4];
	int t_rise[4], wl = 0, len;
	energy_pulse_spacing_output energy_pulse_spacing_output_i (
		.CORE_CLK      (CORE_CLK),
		.RST           (RST),
		.CE_PULSE      (CE_PULSE),
		.PULSE_OUT     (PULSE_OUT),
		.S_AXI_AWADDR  (S_AXI_AWADDR),
		.S_AXI_AWVALID (S_AXI_AWVALID),
		.S_AXI_AWREADY (S_AXI_AWREADY),
		.S_AXI_WDATA   (S_AXI_WDATA),
		.S_AXI_WSTRB   (S_AXI_WSTRB),
		.S_AXI_WVALID  (S_AXI_WVALID),
		.S_AXI_WREADY  (S_AXI_WREADY),
		.S_AXI_BRESP   (S_AXI_BRESP),
		.S_AXI_BVALID  (S_AXI_BVALID),
		.S_AXI_BREADY  (S_AXI_BREADY),
		.S_AXI_ARADDR  (S_AXI_ARADDR),
		.S_AXI_ARVALID (S_AXI_ARVALID),
		.S_AXI_ARREADY (S_AXI_ARREADY),
		.S_AXI_RDATA   (S_AXI_RDATA),
		.S_AXI_RRESP   (S_AXI_RRESP),
		.S_AXI_RVALID  (S_AXI_RVALID),
		.S_AXI_RREADY  (S_AXI_RREADY)
	);
	pulse_engine_model pulse_engine_model_i (.clk(CORE_CLK), .start(start), .chans(chans),
		.num(num), .ce_pulse(CE_PULSE), .busy(busy));
	always #2.5 CORE_CLK = ~CORE_CLK;
	// ====================================================================
	// Pulse counting in true sense
	always @(negedge CORE_CLK) begin
		act = PULSE_OUT ^ {2'b00, ~pol_b, ~pol_b};
		len = (2 * wl + 1) * spc * FILTER_DIV;
		for (int i = 0; i < 4; i++) begin
			if (spc != 0 && !act[i] && act_q[i]) begin
				chk("pulse_width", 1, (cyc - t_rise[i]) inside {[len - FILTER_DIV + 1:len]});
			end
			if (act[i] && !act_q[i]) begin
				n_act[i]++;
				if (spc != 0 && n_act[i] > 1) begin
					chk("spacing_gap", spc * SPACING_MULT * FILTER_DIV, cyc - t_rise[i]);
				end
				t_rise[i] = cyc;
			end
		end
		act_q = act;
	end
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ====================================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [13:0] ix, input logic [31:0] v, input logic [3:0] sb);
		logic a, w, b;
		int   k;
		k = $urandom_range(4);
		S_AXI_AWADDR <= {ix, 2'b00};
		S_AXI_WDATA <= v;
		S_AXI_WSTRB <= sb;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		S_AXI_BREADY <= (k == 0);
		do begin
			@(negedge CORE_CLK);
			a = S_AXI_AWVALID & S_AXI_AWREADY;
			w = S_AXI_WVALID & S_AXI_WREADY;
			b = S_AXI_BVALID & S_AXI_BREADY;
			r = S_AXI_BRESP;
			@(posedge CORE_CLK);
			if (a) S_AXI_AWVALID <= 0;
			if (w) S_AXI_WVALID <= 0;
			k--;
			if (k == 0) S_AXI_BREADY <= 1;
		end while (!b);
		S_AXI_BREADY <= 0;
		@(posedge CORE_CLK);
	endtask
	task automatic rd(input logic [13:0] ix);
		logic a, v;
		int   k;
		k = $urandom_range(4);
		S_AXI_ARADDR <= {ix, 2'b00};
		S_AXI_ARVALID <= 1;
		S_AXI_RREADY <= (k == 0);
		do begin
			@(negedge CORE_CLK);
			a = S_AXI_ARVALID & S_AXI_ARREADY;
			v = S_AXI_RVALID & S_AXI_RREADY;
			d = S_AXI_RDATA;
			r = S_AXI_RRESP;
			@(posedge CORE_CLK);
			if (a) S_AXI_ARVALID <= 0;
			k--;
			if (k == 0) S_AXI_RREADY <= 1;
		end while (!v);
		S_AXI_RREADY <= 0;
		@(posedge CORE_CLK);
	endtask
	task automatic burst(input logic [3:0] c, input int n, input int waitc);
		repeat (4) @(posedge CORE_CLK);
		for (int i = 0; i < 4; i++) n_act[i] = 0;
		for (int i = 0; i < 4; i++) n_exp[i] = c[i] ? n : 0;
		chans <= c;
		num <= 8'(n);
		start <= 1;
		@(posedge CORE_CLK);
		start <= 0;
		do @(negedge CORE_CLK); while (busy);
		repeat (waitc) @(posedge CORE_CLK);
	endtask
	task automatic report_and_stop();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ====================================================================
	// Main sequence
	initial begin
		void'($urandom(32'h753C58CA));
		repeat (4) @(posedge CORE_CLK);
		RST <= 0;
		@(posedge CORE_CLK);
		rd(IDX_WIDTH_LIMIT); chk("width_reset", 32'hFF, d);
		rd(IDX_SPACING); chk("spacing_reset", 32'h0, d);
		rd(IDX_POLARITY); chk("polarity_reset", 32'h0, d);
		rd(14'h0001); chk("unmapped_read", RESP_SLVERR, r);
		wr(14'h0001, 32'h1, 4'hF); chk("unmapped_write", RESP_SLVERR, r);
		wr(IDX_STATUS, 32'hFF, 4'h1);
		chk("status_write", RESP_OKAY, r);
		rd(IDX_STATUS);
		chk("status_idle", 32'h0, d);
		for (int p = 0; p < 2; p++) begin
			pol_b = p[0] ^ 1'($urandom_range(1));
			wr(IDX_POLARITY, {31'h0, pol_b}, 4'h1);
			rd(IDX_POLARITY); chk("polarity", {31'h0, pol_b}, d);
			burst(4'hD | 4'($urandom), 4, 6);
			for (int i = 0; i < 4; i++) chk("bypass_count", n_exp[i], n_act[i]);
			chk("idle_level", {30'h0, ~pol_b, ~pol_b}, {28'h0, PULSE_OUT});
		end
		spc = 24 * (1 + $urandom_range(1)) / 6 / 4;
		wl = $urandom_range(1);
		wr(IDX_WIDTH_LIMIT, wl, 4'h1);
		chk("write_okay", RESP_OKAY, r);
		wr(IDX_SPACING, spc, 4'h1);
		wr(IDX_SPACING, 32'h7, 4'h0);
		rd(IDX_SPACING); chk("spacing_strobe", spc, d);
		burst(4'hF, 5, 7 * spc * 160);
		for (int i = 0; i < 4; i++) chk("spaced_count", n_exp[i], n_act[i]);
		burst(4'h1, 17, 18 * spc * 160);
		chk("queue_limit", 1, n_act[0] inside {15, 16});
		report_and_stop();
	end
endmodule
